// [rtl/stp_consts.vh]
`ifndef STP_CONSTS_VH
`define STP_CONSTS_VH
// instruction codes
`define STP_IR_W          3
`define STP_OP_EXTEST     3'h0
`define STP_OP_IDCODE     3'h1
`define STP_OP_SAMPLEZ    3'h2
`define STP_OP_SAMPLE     3'h4
`define STP_OP_BYPASS     3'h7
`define STP_IR_CAPTURE    3'h1
// identification layout
`define STP_ID_W          32
`define STP_ID_REV_W      3
`define STP_ID_PART_W     17
`define STP_ID_MFR_W      11
`define STP_ID_PRESENT    1'h1
// boundary chain
`define STP_BSR_W         109
`define STP_BSR_CTL_BIT   108
`define STP_BSR_PINS      108
`endif

// [rtl/stp_test_port.v]
`timescale 1ns/1ns
`include "stp_consts.vh"
module stp_test_port #(
    parameter [`STP_ID_REV_W-1:0]  REV_ID  = 3'h0,        // arbitrary value
    parameter [`STP_ID_PART_W-1:0] PART_ID = 17'h00001,   // arbitrary value
    parameter [`STP_ID_MFR_W-1:0]  MFR_ID  = 11'h001      // arbitrary value
) (
    // system
    input  wire                      clk,
    input  wire                      rst,
    // test link
    input  wire                      tck,
    input  wire                      tms,
    input  wire                      tdi,
    output reg                       tdo_q,
    output reg                       tdo_oe_q,
    // package ring
    input  wire [`STP_BSR_PINS-1:0]  pin_in,
    output reg  [`STP_BSR_PINS-1:0]  pin_drive_q,
    output reg                       extest_q,
    output reg                       out_en_q
);
    reg  [1:0]                   tck_s;
    reg  [1:0]                   tms_s;
    reg  [1:0]                   tdi_s;
    reg                          tck_prev_q;
    reg  [3:0]                   st_q;
    reg  [3:0]                   st_d;
    reg  [`STP_IR_W-1:0]         ir_sh_q;
    reg  [`STP_IR_W-1:0]         ir_q;
    reg                          byp_q;
    reg  [`STP_ID_W-1:0]         id_sh_q;
    reg  [`STP_BSR_W-1:0]        bsr_sh_q;
    reg  [`STP_BSR_W-1:0]        bsr_up_q;
    reg                          so_d;
    reg  [`STP_BSR_PINS-1:0]     pin_s1_q;
    reg  [`STP_BSR_PINS-1:0]     pin_s2_q;
    wire                         rise;
    wire                         fall;
    wire                         shifting;
    wire [`STP_ID_W-1:0]         id_val;
    wire                         use_bsr;

    // controller states
    localparam [3:0] S_RESET    = 4'h0;
    localparam [3:0] S_IDLE     = 4'h1;
    localparam [3:0] S_SEL_DR   = 4'h2;
    localparam [3:0] S_CAP_DR   = 4'h3;
    localparam [3:0] S_SHIFT_DR = 4'h4;
    localparam [3:0] S_EXIT1_DR = 4'h5;
    localparam [3:0] S_PAUSE_DR = 4'h6;
    localparam [3:0] S_EXIT2_DR = 4'h7;
    localparam [3:0] S_UPD_DR   = 4'h8;
    localparam [3:0] S_SEL_IR   = 4'h9;
    localparam [3:0] S_CAP_IR   = 4'hA;
    localparam [3:0] S_SHIFT_IR = 4'hB;
    localparam [3:0] S_EXIT1_IR = 4'hC;
    localparam [3:0] S_PAUSE_IR = 4'hD;
    localparam [3:0] S_EXIT2_IR = 4'hE;
    localparam [3:0] S_UPD_IR   = 4'hF;

    // codes that put the boundary chain in the path
    function is_bsr_op;
        input [`STP_IR_W-1:0] op;
        begin
            is_bsr_op = (op == `STP_OP_EXTEST) || (op == `STP_OP_SAMPLEZ)
                     || (op == `STP_OP_SAMPLE);
        end
    endfunction

    assign rise = tck_s[1] & ~tck_prev_q;
    assign fall = ~tck_s[1] & tck_prev_q;
    assign shifting = (st_q == S_SHIFT_IR) || (st_q == S_SHIFT_DR);
    assign id_val = {REV_ID, PART_ID, MFR_ID, `STP_ID_PRESENT};
    assign use_bsr = is_bsr_op(ir_q);

    // synchronise the slow link into clk; tck period is many clk cycles
    // ring pins are asynchronous too; capture may lag a pin by two clk
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tck_s      <= 2'h0;
            tms_s      <= 2'h3;
            tdi_s      <= 2'h0;
            tck_prev_q <= 1'h0;
            pin_s1_q   <= {`STP_BSR_PINS{1'h0}};
            pin_s2_q   <= {`STP_BSR_PINS{1'h0}};
        end else begin
            tck_s      <= {tck_s[0], tck};
            tms_s      <= {tms_s[0], tms};
            tdi_s      <= {tdi_s[0], tdi};
            tck_prev_q <= tck_s[1];
            pin_s1_q   <= pin_in;
            pin_s2_q   <= pin_s1_q;
        end
    end

    // controller next state
    always @* begin
        case (st_q)
            S_RESET:    st_d = tms_s[1] ? S_RESET : S_IDLE;
            S_IDLE:     st_d = tms_s[1] ? S_SEL_DR : S_IDLE;
            S_SEL_DR:   st_d = tms_s[1] ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR:   st_d = tms_s[1] ? S_EXIT1_DR : S_SHIFT_DR;
            S_SHIFT_DR: st_d = tms_s[1] ? S_EXIT1_DR : S_SHIFT_DR;
            S_EXIT1_DR: st_d = tms_s[1] ? S_UPD_DR : S_PAUSE_DR;
            S_PAUSE_DR: st_d = tms_s[1] ? S_EXIT2_DR : S_PAUSE_DR;
            S_EXIT2_DR: st_d = tms_s[1] ? S_UPD_DR : S_SHIFT_DR;
            S_UPD_DR:   st_d = tms_s[1] ? S_SEL_DR : S_IDLE;
            S_SEL_IR:   st_d = tms_s[1] ? S_RESET : S_CAP_IR;
            S_CAP_IR:   st_d = tms_s[1] ? S_EXIT1_IR : S_SHIFT_IR;
            S_SHIFT_IR: st_d = tms_s[1] ? S_EXIT1_IR : S_SHIFT_IR;
            S_EXIT1_IR: st_d = tms_s[1] ? S_UPD_IR : S_PAUSE_IR;
            S_PAUSE_IR: st_d = tms_s[1] ? S_EXIT2_IR : S_PAUSE_IR;
            S_EXIT2_IR: st_d = tms_s[1] ? S_UPD_IR : S_SHIFT_IR;
            default:    st_d = tms_s[1] ? S_SEL_DR : S_IDLE;
        endcase
    end

    // serial output source
    always @* begin
        if (st_q == S_SHIFT_IR) begin
            so_d = ir_sh_q[0];
        end else if (ir_q == `STP_OP_IDCODE) begin
            so_d = id_sh_q[0];
        end else if (use_bsr) begin
            so_d = bsr_sh_q[0];
        end else begin
            so_d = byp_q;
        end
    end

    // unimplemented codes fall back to bypass; the tester must not load them
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q     <= S_RESET;
            ir_sh_q  <= `STP_IR_CAPTURE;
            ir_q     <= `STP_OP_IDCODE;
            byp_q    <= 1'h0;
            id_sh_q  <= {`STP_ID_W{1'b0}};
            bsr_sh_q <= {`STP_BSR_W{1'b0}};
            bsr_up_q <= {1'b1, {`STP_BSR_PINS{1'b0}}};
        end else if (rise) begin
            st_q <= st_d;
            case (st_q)
                S_RESET: begin
                    ir_q <= `STP_OP_IDCODE;
                    bsr_up_q[`STP_BSR_CTL_BIT] <= 1'h1;
                end
                S_CAP_IR: ir_sh_q <= `STP_IR_CAPTURE;
                S_SHIFT_IR: ir_sh_q <= {tdi_s[1], ir_sh_q[`STP_IR_W-1:1]};
                S_UPD_IR: ir_q <= ir_sh_q;
                S_CAP_DR: begin
                    byp_q <= 1'h0;
                    if (ir_q == `STP_OP_IDCODE) begin
                        id_sh_q <= id_val;
                    end
                    if (use_bsr) begin
                        bsr_sh_q <= {bsr_up_q[`STP_BSR_CTL_BIT], pin_s2_q};
                    end
                end
                S_SHIFT_DR: begin
                    byp_q   <= tdi_s[1];
                    id_sh_q <= {tdi_s[1], id_sh_q[`STP_ID_W-1:1]};
                    if (use_bsr) begin
                        bsr_sh_q <= {tdi_s[1], bsr_sh_q[`STP_BSR_W-1:1]};
                    end
                end
                S_UPD_DR: begin
                    if (use_bsr) begin
                        bsr_up_q <= bsr_sh_q;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // outputs; tdo moves on the falling tck edge as the link expects
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tdo_q       <= 1'h0;
            tdo_oe_q    <= 1'h0;
            pin_drive_q <= {`STP_BSR_PINS{1'b0}};
            extest_q    <= 1'h0;
            out_en_q    <= 1'h1;
        end else begin
            // tdo keeps its last bit outside the shift states
            if (fall) begin
                if (shifting) begin
                    tdo_q <= so_d;
                end
                tdo_oe_q <= shifting;
            end
            pin_drive_q <= bsr_up_q[`STP_BSR_PINS-1:0];
            extest_q    <= (ir_q == `STP_OP_EXTEST);
            if (ir_q == `STP_OP_SAMPLEZ) begin
                out_en_q <= 1'b0;
            end else if (ir_q == `STP_OP_EXTEST) begin
                out_en_q <= bsr_up_q[`STP_BSR_CTL_BIT];
            end else begin
                out_en_q <= 1'b1;
            end
        end
    end
endmodule

// [dv/stp_test_port_assertions.sv]
`timescale 1ns/1ns
module stp_chk (
    // system
    input logic         clk,
    input logic         rst,
    // link
    input logic         tck,
    input logic         tdo_q,
    input logic         tdo_oe_q,
    // ring
    input logic [107:0] pin_drive_q,
    input logic         extest_q,
    input logic         out_en_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_tdo_idle: assert property (!tdo_oe_q && $past(!tdo_oe_q) |-> $stable(tdo_q))
        else $error("tdo moved while idle");
    chk_tdo_on_fall: assert property ($changed(tdo_q) |-> !$past(tck) && !$past(tck, 2))
        else $error("tdo moved off a fall");
    chk_oe_up_fall: assert property ($rose(tdo_oe_q) |-> !$past(tck, 2))
        else $error("oe rose off a fall");
    chk_oe_dn_fall: assert property ($fell(tdo_oe_q) |-> !$past(tck, 2))
        else $error("oe fell off a fall");
    chk_drive_hold: assert property (tdo_oe_q |-> $stable(pin_drive_q))
        else $error("drive moved in shift");
    chk_instr_hold: assert property (tdo_oe_q |-> $stable(extest_q) && $stable(out_en_q))
        else $error("mode moved in shift");
    chk_extest_rise: assert property ($rose(extest_q) |-> $past(tck, 2))
        else $error("extest off a rise");
    chk_float_rise: assert property ($fell(out_en_q) |-> $past(tck, 2))
        else $error("float off a rise");
    cover property ($fell(out_en_q));
    cover property ($rose(extest_q));
    cover property ($changed(pin_drive_q));
endmodule

bind stp_test_port stp_chk stp_chk_i (.clk, .rst, .tck, .tdo_q, .tdo_oe_q,
    .pin_drive_q, .extest_q, .out_en_q);

// [dv/stp_host.sv]
`timescale 1ns/1ns
module stp_host (
    // system
    input  logic clk,
    // link
    input  logic tdo_q,
    output logic tck = 1'b0,
    output logic tms = 1'b1,
    output logic tdi = 1'b0
);
    // low 5 clk, high 3 clk; tdo read just before the rise
    task automatic step(input logic m, d, output logic o);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (5) @(posedge clk);
        #1 o = tdo_q;
        tck = 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // idle tdi toggles so a stale value never looks valid
    task automatic scan(input bit ir, input int n, input logic [108:0] din,
                        output logic [108:0] dout);
        logic o;
        dout = '0;
        step(1, ~tdi, o);
        if (ir) step(1, ~tdi, o);
        step(0, ~tdi, o);
        step(0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1, ~tdi, o);
        step(0, ~tdi, o);
        idle(); // outputs follow the update rise by one clk
    endtask
    // one idle rise; leaves the controller in run-test/idle
    task automatic idle();
        logic o;
        step(0, ~tdi, o);
    endtask
    task automatic tlr();
        logic o;
        repeat (5) step(1, ~tdi, o);
        step(0, ~tdi, o);
    endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/1ns
module tb;
    localparam logic [2:0]  REV  = 3'h5;     // arbitrary value
    localparam logic [16:0] PART = 17'h0ABCD; // arbitrary value
    localparam logic [10:0] MFR  = 11'h2A5;  // arbitrary value
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         ctl = 1'b1;
    logic         tck, tms, tdi, tdo_q, tdo_oe_q, extest_q, out_en_q;
    logic [107:0] pin_in = '0;
    logic [107:0] pin_drive_q;
    logic [108:0] got, sent;
    logic [2:0]   codes[4] = '{3'h2, 3'h4, 3'h7, 3'h0};
    int           bad_count = 0;
    int           n_checks = 0;
    int           seed = 32'h4DC7;
    always #50 clk = ~clk;
    stp_test_port #(.REV_ID(REV), .PART_ID(PART), .MFR_ID(MFR)) stp_test_port_i (
        .clk, .rst, .tck, .tms, .tdi, .tdo_q, .tdo_oe_q,
        .pin_in, .pin_drive_q, .extest_q, .out_en_q);
    stp_host stp_host_i (.clk, .tdo_q, .tck, .tms, .tdi);
    function automatic logic [108:0] dexp(input logic [2:0] c);
        if (c == 3'h7)
            return {101'h0, sent[6:0], 1'b0};
        return {ctl, pin_in};
    endfunction
    function automatic logic oexp(input logic [2:0] c);
        return c == 3'h0 ? ctl : c != 3'h2;
    endfunction
    task automatic check(input logic [108:0] g, e, input string m);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1 check(out_en_q, 1, "preset enable");
        stp_host_i.idle();
        stp_host_i.scan(0, 32, '0, got);
        check(got, {77'h0, REV, PART, MFR, 1'b1}, "id word");
        check(tdo_oe_q, 0, "oe idle");
        foreach (codes[k]) begin
            stp_host_i.scan(1, 3, {106'h0, codes[k]}, got);
            check(got, 109'h1, "ir capture");
            check(extest_q, codes[k] == 3'h0, "extest flag");
            check(out_en_q, oexp(codes[k]), "enable after ir");
            pin_in = 108'({$random(seed), $random(seed), $random(seed), $random(seed)});
            sent = 109'({$random(seed), $random(seed), $random(seed), $random(seed)});
            sent[108] = codes[k] == 3'h0;
            stp_host_i.scan(0, codes[k] == 3'h7 ? 8 : 109, sent, got);
            check(got, dexp(codes[k]), "dr capture");
            if (codes[k] != 3'h7) begin
                ctl = sent[108];
                check(pin_drive_q, sent[107:0], "preload");
            end
            check(out_en_q, oexp(codes[k]), "enable after dr");
        end
        stp_host_i.scan(0, 109, '0, got);
        check(got, dexp(3'h0), "extest capture");
        check(out_en_q, 0, "extest float");
        check(pin_drive_q, 0, "extest drive");
        stp_host_i.tlr();
        check({extest_q, out_en_q}, 2'b01, "reset mode");
        stp_host_i.scan(0, 32, '0, got);
        check(got, {77'h0, REV, PART, MFR, 1'b1}, "id again");
        stp_host_i.scan(1, 3, 109'h0, got);
        check(out_en_q, 1, "preset after reset");
        test_done();
    end
endmodule
